/* File: common/lpacr_pkg.sv */
package lpacr_pkg;

  // register addresses on the internal register port
  localparam logic [7:0] PAT_CTRL_ADDR = 8'h11;
  localparam logic [7:0] LIM_ONE_ADDR = 8'h12;
  localparam logic [7:0] LIM_TWO_ADDR = 8'h13;
  localparam logic [7:0] AUDIO_ONE_ADDR = 8'h2a;

  // pattern control bit positions
  localparam int BLINK_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int LOOP_BIT = 1;
  localparam int LAW_BIT = 0;

  // current limit field positions
  localparam int RED_LSB = 4;
  localparam int GREEN_LSB = 2;
  localparam int BLUE_LSB = 0;

  // audio control field positions
  localparam int GAIN_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int AGC_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int SEL_LSB = 0;

  // values after reset
  localparam logic [3:0] PAT_RESET = 4'h0;
  localparam logic [5:0] LIM_RESET = 6'h00;
  localparam logic [7:0] AUDIO_RESET = 8'h03;

  // codings
  localparam logic [4:0] GAIN_STEP_DB = 5'h03;
  localparam logic [1:0] SEL_SINGLE = 2'h0;
  localparam logic [1:0] SEL_NONE = 2'h3;
  localparam int NUM_CMDS = 8;

  typedef struct packed {
    logic blink_en;
    logic run;
    logic loop_en;
    logic law;
  } lpacr_pat_t;

  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
  } lpacr_limit_t;

  typedef struct packed {
    logic [2:0] gain;
    logic freq_mode;
    logic agc;
    logic sync_en;
    logic [1:0] sel;
  } lpacr_audio_t;

  typedef struct packed {
    logic pattern_one;
    logic pattern_two;
    logic audio_one;
    logic audio_two;
    logic blink_one;
  } lpacr_owner_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } lpacr_seq_t;

endpackage : lpacr_pkg

/* File: src/lpacr_regs.sv */
`timescale 1ns/1ns
module lpacr_regs #(
  parameter int NUM_CMDS = lpacr_pkg::NUM_CMDS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // command engine
  input wire logic cmd_done,
  input wire logic [1:0] mode_sel,
  input wire logic [2:0] lvl_red,
  input wire logic [2:0] lvl_green,
  input wire logic [2:0] lvl_blue,
  // configuration out
  output lpacr_pkg::lpacr_pat_t pat_cfg,
  output lpacr_pkg::lpacr_limit_t lim_one,
  output lpacr_pkg::lpacr_limit_t lim_two,
  output lpacr_pkg::lpacr_audio_t audio_cfg,
  output lpacr_pkg::lpacr_owner_t owner,
  output logic blink_allowed,
  output logic [8:0] quarters_one,
  output logic [8:0] quarters_two,
  output logic [4:0] gain_db,
  output logic adc_single_ended,
  output logic audio_active,
  // sequencer status
  output logic seq_running,
  output logic [2:0] cmd_index,
  output logic [6:0] pct_red,
  output logic [6:0] pct_green,
  output logic [6:0] pct_blue
);

  if (NUM_CMDS < 2 || NUM_CMDS > 8) begin : g_bad_cmds
    $error("NUM_CMDS must lie in 2..8");
  end

  localparam logic [2:0] LAST_CMD = 3'(NUM_CMDS - 1);

  // percent of the channel maximum for a level code under either law
  function automatic logic [6:0] level_pct(input logic [2:0] code, input logic law);
    logic [6:0] pct;
    pct = 7'h00;
    unique case (code)
      3'h0: pct = 7'h00;
      3'h1: pct = law ? 7'h01 : 7'h07;
      3'h2: pct = law ? 7'h02 : 7'h0e;
      3'h3: pct = law ? 7'h04 : 7'h15;
      3'h4: pct = law ? 7'h0a : 7'h20;
      3'h5: pct = law ? 7'h15 : 7'h2e;
      3'h6: pct = law ? 7'h2e : 7'h47;
      3'h7: pct = 7'h64;
    endcase
    return pct;
  endfunction : level_pct

  // current scale in quarters of full scale, three channels
  function automatic logic [8:0] limit_quarters(input lpacr_pkg::lpacr_limit_t lim);
    return {3'({1'b0, lim.red} + 3'h1), 3'({1'b0, lim.green} + 3'h1),
            3'({1'b0, lim.blue} + 3'h1)};
  endfunction : limit_quarters

  lpacr_pkg::lpacr_seq_t seq_state, next_seq_state;
  logic [2:0] next_cmd_index;
  lpacr_pkg::lpacr_pat_t next_pat_cfg;
  lpacr_pkg::lpacr_limit_t next_lim_one, next_lim_two;
  lpacr_pkg::lpacr_audio_t next_audio_cfg;
  lpacr_pkg::lpacr_owner_t next_owner;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic start_write;
  logic next_seq_running;

  always_comb begin
    next_pat_cfg = pat_cfg;
    next_lim_one = lim_one;
    next_lim_two = lim_two;
    next_audio_cfg = audio_cfg;
    next_seq_state = seq_state;
    next_cmd_index = cmd_index;
    next_reg_rdata = 8'h00;
    next_reg_rvalid = reg_rd;
    start_write = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        lpacr_pkg::PAT_CTRL_ADDR: begin
          next_pat_cfg = reg_wdata[3:0];
          start_write = reg_wdata[lpacr_pkg::RUN_BIT];
        end
        lpacr_pkg::LIM_ONE_ADDR: next_lim_one = reg_wdata[5:0];
        lpacr_pkg::LIM_TWO_ADDR: next_lim_two = reg_wdata[5:0];
        lpacr_pkg::AUDIO_ONE_ADDR: next_audio_cfg = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        lpacr_pkg::PAT_CTRL_ADDR: next_reg_rdata = {4'h0, pat_cfg};
        lpacr_pkg::LIM_ONE_ADDR: next_reg_rdata = {2'h0, lim_one};
        lpacr_pkg::LIM_TWO_ADDR: next_reg_rdata = {2'h0, lim_two};
        lpacr_pkg::AUDIO_ONE_ADDR: next_reg_rdata = audio_cfg;
        default: next_reg_rdata = 8'h00;
      endcase
    end
    // sequencer: restart on any write of run=1, stop when run cleared
    if (start_write) begin
      next_seq_state = lpacr_pkg::SEQ_RUN;
      next_cmd_index = 3'h0;
    end else if (!next_pat_cfg.run) begin
      next_seq_state = lpacr_pkg::SEQ_IDLE;
      next_cmd_index = 3'h0;
    end else if (seq_state == lpacr_pkg::SEQ_RUN && cmd_done) begin
      if (cmd_index == LAST_CMD) begin
        next_cmd_index = 3'h0;
        // single pass parks at command 1; run bit stays as written
        if (!pat_cfg.loop_en) begin
          next_seq_state = lpacr_pkg::SEQ_IDLE;
        end
      end else begin
        next_cmd_index = 3'(cmd_index + 3'h1);
      end
    end
    unique case (mode_sel)
      2'h0: next_owner = 5'b11000;
      2'h1: next_owner = 5'b01001;
      2'h2: next_owner = 5'b10010;
      2'h3: next_owner = 5'b00110;
    endcase
    // status flop mirrors the state so the port leaves a register
    next_seq_running = next_seq_state == lpacr_pkg::SEQ_RUN;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pat_cfg <= lpacr_pkg::PAT_RESET;
      lim_one <= lpacr_pkg::LIM_RESET;
      lim_two <= lpacr_pkg::LIM_RESET;
      audio_cfg <= lpacr_pkg::AUDIO_RESET;
      seq_state <= lpacr_pkg::SEQ_IDLE;
      cmd_index <= 3'h0;
      seq_running <= 1'b0;
      owner <= 5'h00;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      pat_cfg <= next_pat_cfg;
      lim_one <= next_lim_one;
      lim_two <= next_lim_two;
      audio_cfg <= next_audio_cfg;
      seq_state <= next_seq_state;
      cmd_index <= next_cmd_index;
      seq_running <= next_seq_running;
      owner <= next_owner;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // decoded outputs, registered one cycle behind the fields
  logic next_blink_allowed, next_single_ended, next_audio_active;
  logic [8:0] next_quarters_one, next_quarters_two;
  logic [4:0] next_gain_db;
  logic [6:0] next_pct_red, next_pct_green, next_pct_blue;

  always_comb begin
    next_blink_allowed = pat_cfg.blink_en && owner.blink_one;
    next_quarters_one = limit_quarters(lim_one);
    next_quarters_two = limit_quarters(lim_two);
    next_gain_db = 5'(audio_cfg.gain * lpacr_pkg::GAIN_STEP_DB);
    // unused selector codes route nothing, like the no-input code
    next_single_ended = audio_cfg.sel == lpacr_pkg::SEL_SINGLE;
    next_audio_active = audio_cfg.sync_en && audio_cfg.sel == lpacr_pkg::SEL_SINGLE;
    next_pct_red = level_pct(lvl_red, pat_cfg.law);
    next_pct_green = level_pct(lvl_green, pat_cfg.law);
    next_pct_blue = level_pct(lvl_blue, pat_cfg.law);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      blink_allowed <= 1'b0;
      quarters_one <= 9'h049;
      quarters_two <= 9'h049;
      gain_db <= 5'h00;
      adc_single_ended <= 1'b0;
      audio_active <= 1'b0;
      pct_red <= 7'h00;
      pct_green <= 7'h00;
      pct_blue <= 7'h00;
    end else begin
      blink_allowed <= next_blink_allowed;
      quarters_one <= next_quarters_one;
      quarters_two <= next_quarters_two;
      gain_db <= next_gain_db;
      adc_single_ended <= next_single_ended;
      audio_active <= next_audio_active;
      pct_red <= next_pct_red;
      pct_green <= next_pct_green;
      pct_blue <= next_pct_blue;
    end
  end

  a_blink_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !pat_cfg.blink_en |=> !blink_allowed)
    else $error("blink allowed while blink bit clear");
  a_run_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == lpacr_pkg::PAT_CTRL_ADDR && reg_wdata[2]
    |=> seq_running && cmd_index == 3'h0)
    else $error("run write did not start at command one");
  a_run_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    !pat_cfg.run |-> !seq_running)
    else $error("sequencer running with run bit clear");
  a_once_end: assert property (@(posedge core_clk) disable iff (sys_rst)
    seq_running && cmd_done && cmd_index == LAST_CMD && !pat_cfg.loop_en && !reg_wr
    |=> !seq_running)
    else $error("single pass did not stop");
  a_loop_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    seq_running && cmd_done && cmd_index == LAST_CMD && pat_cfg.loop_en && !reg_wr
    |=> seq_running && cmd_index == 3'h0)
    else $error("loop did not wrap to command one");
  a_law_top: assert property (@(posedge core_clk) disable iff (sys_rst)
    lvl_red == 3'h4 ##1 lvl_red == $past(lvl_red) |-> pct_red == ($past(pat_cfg.law) ? 7'h0a : 7'h20))
    else $error("intensity law mismatch");
  a_limit_scale: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == lpacr_pkg::LIM_ONE_ADDR && reg_wdata[5:4] == 2'h2
    |=> ##1 quarters_one[8:6] == 3'h3)
    else $error("limit scale wrong");
  a_gain_steps: assert property (@(posedge core_clk) disable iff (sys_rst)
    audio_cfg.gain == 3'h7 |=> gain_db == 5'h15)
    else $error("gain not 21 dB at top code");
  a_upper_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == lpacr_pkg::LIM_TWO_ADDR |=> reg_rvalid && reg_rdata[7:6] == 2'h0)
    else $error("upper bits not zero");
  a_sync_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !audio_cfg.sync_en |=> !audio_active)
    else $error("audio active while sync disabled");

endmodule : lpacr_regs

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic core_clk, sys_rst, reg_wr, reg_rd, cmd_done, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, up;
  logic [1:0] mode_sel, r, g, b;
  logic [2:0] lvl_red, lvl_green, lvl_blue;
  lpacr_pkg::lpacr_pat_t pat_cfg;
  lpacr_pkg::lpacr_limit_t lim_one, lim_two;
  lpacr_pkg::lpacr_audio_t audio_cfg;
  lpacr_pkg::lpacr_owner_t owner;
  logic blink_allowed, adc_single_ended, audio_active, seq_running;
  logic [8:0] quarters_one, quarters_two;
  logic [4:0] gain_db;
  logic [2:0] cmd_index;
  logic [6:0] pct_red, pct_green, pct_blue;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [6:0] pct_tab[2][8] = '{'{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64},
    '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64}};
  logic [4:0] own_tab[4] = '{5'h18, 5'h09, 5'h12, 5'h06};

  // short sequencer so both wrap and single pass stay quick
  lpacr_regs #(.NUM_CMDS(4)) lpacr_regs_i (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .cmd_done, .mode_sel, .lvl_red, .lvl_green,
    .lvl_blue, .pat_cfg, .lim_one, .lim_two, .audio_cfg, .owner, .blink_allowed,
    .quarters_one, .quarters_two, .gain_db, .adc_single_ended, .audio_active,
    .seq_running, .cmd_index, .pct_red, .pct_green, .pct_blue);

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  function automatic logic [2:0] q(input logic [1:0] x);
    return {1'b0, x} + 3'h1;
  endfunction : q

  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge core_clk);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask : rd

  task settle;
    repeat (3) @(negedge core_clk);
  endtask : settle

  task pulse;
    @(negedge core_clk);
    cmd_done = 1'b1;
    @(negedge core_clk);
    cmd_done = 1'b0;
  endtask : pulse

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // read data stands one cycle, so it is taken at the following falling edge
  always @(negedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious_rvalid", 9'h001, 9'h000);
      else chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    void'($urandom(32'h2701bbfa));
    sys_rst = 1'b1;
    {reg_wr, reg_rd, cmd_done, reg_addr, reg_wdata, mode_sel} = '0;
    {lvl_red, lvl_green, lvl_blue} = '0;
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("quarters_one", quarters_one, 9'h049);
    chk("quarters_two", quarters_two, 9'h049);
    chk("gain_db", gain_db, 9'h000);
    rd(lpacr_pkg::PAT_CTRL_ADDR, 8'h00);
    rd(lpacr_pkg::LIM_ONE_ADDR, 8'h00);
    rd(lpacr_pkg::LIM_TWO_ADDR, 8'h00);
    rd(lpacr_pkg::AUDIO_ONE_ADDR, 8'h03);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'hf9);
    rd(lpacr_pkg::PAT_CTRL_ADDR, 8'h09);
    chk("pat_cfg", pat_cfg, 9'h009);
    for (int m = 0; m < 4; m++) begin
      @(negedge core_clk);
      mode_sel = 2'(m);
      settle();
      chk("owner", owner, own_tab[m]);
      chk("blink_allowed", blink_allowed, 9'(m == 1));
    end
    mode_sel = 2'h1;
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'h00);
    settle();
    chk("blink_allowed", blink_allowed, 9'h000);
    for (int l = 0; l < 2; l++) begin
      wr(lpacr_pkg::PAT_CTRL_ADDR, 8'(l));
      for (int c = 0; c < 8; c++) begin
        @(negedge core_clk);
        lvl_red = 3'(c);
        lvl_green = 3'(7 - c);
        lvl_blue = 3'($urandom);
        settle();
        chk("pct_red", pct_red, pct_tab[l][c]);
        chk("pct_green", pct_green, pct_tab[l][7 - c]);
        chk("pct_blue", pct_blue, pct_tab[l][lvl_blue]);
      end
    end
    // each field sees all four codes across the loop
    for (int i = 0; i < 4; i++) begin
      r = 2'(i);
      g = 2'(i + 1);
      b = 2'(i + 2);
      up = 8'($urandom);
      wr(lpacr_pkg::LIM_ONE_ADDR, {up[1:0], r, g, b});
      wr(lpacr_pkg::LIM_TWO_ADDR, {up[3:2], b, r, g});
      settle();
      chk("quarters_one", quarters_one, {q(r), q(g), q(b)});
      chk("quarters_two", quarters_two, {q(b), q(r), q(g)});
      chk("lim_one", lim_one, {3'h0, r, g, b});
      chk("lim_two", lim_two, {3'h0, b, r, g});
      rd(lpacr_pkg::LIM_ONE_ADDR, {2'h0, r, g, b});
      rd(lpacr_pkg::LIM_TWO_ADDR, {2'h0, b, r, g});
    end
    for (int gn = 0; gn < 8; gn++) begin
      a = 8'($urandom);
      a[7:5] = 3'(gn);
      a[1:0] = a[1] ? 2'h3 : 2'h0;
      wr(lpacr_pkg::AUDIO_ONE_ADDR, a);
      rd(lpacr_pkg::AUDIO_ONE_ADDR, a);
      settle();
      chk("gain_db", gain_db, 9'(gn * 3));
      chk("audio_cfg", audio_cfg, {1'b0, a});
      chk("adc_single_ended", adc_single_ended, 9'(a[1:0] == 2'h0));
      chk("audio_active", audio_active, 9'(a[2] && a[1:0] == 2'h0));
    end
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'h06);
    chk("seq_running", seq_running, 9'h001);
    for (int k = 1; k <= 4; k++) begin
      pulse();
      @(negedge core_clk);
      chk("cmd_index", cmd_index, 9'(k % 4));
      chk("seq_running", seq_running, 9'h001);
    end
    pulse();
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'h04);
    chk("cmd_index", cmd_index, 9'h000);
    for (int k = 1; k <= 4; k++) begin
      pulse();
      @(negedge core_clk);
      chk("seq_running", seq_running, 9'(k < 4));
    end
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'h06);
    pulse();
    wr(lpacr_pkg::PAT_CTRL_ADDR, 8'h02);
    @(negedge core_clk);
    chk("seq_running", seq_running, 9'h000);
    repeat (4) @(negedge core_clk);
    chk("reads_pending", 9'(exp_q.size()), 9'h000);
    end_sim();
  end
endmodule : testbench
